// >>> hdl/acc_pkg.sv
package acc_pkg;

  // register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_CHANNEL_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_REF_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;

  // field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_START = 1;
  localparam int CHS_LSB = 2;
  localparam int BIT_REF_SEL = 0;
  localparam int CCS_LSB = 4;
  localparam int BIT_DONE = 0;

  // reset values
  localparam logic [7:0] RST_CHANNEL_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_REF_CONTROL = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;

  // conversion timing, in conversion-clock periods
  localparam logic [3:0] CONV_PERIODS = 4'd11;
  localparam logic [1:0] ABORT_PERIODS = 2'd2;

  // divider terms, in ref_clk cycles per conversion-clock period
  localparam logic [6:0] DIV_8 = 7'd8;
  localparam logic [6:0] DIV_16 = 7'd16;
  localparam logic [6:0] DIV_32 = 7'd32;
  localparam logic [6:0] DIV_64 = 7'd64;
  localparam logic [6:0] DIV_RC = 7'd16;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_CONVERT,
    ACC_RECOVER
  } acc_state_t;

  // sample result handed in from the analog front end
  typedef struct packed {
    logic valid;
    logic [9:0] value;
  } acc_sample_t;

endpackage

// >>> hdl/acc_core.sv
`timescale 1ns/1ps
module acc_core
  import acc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sleep_mode,
  input wire acc_sample_t sample_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [4:0] channel_select,
  output logic converter_on,
  output logic reference_select,
  output logic sample_hold,
  output logic acquire,
  output logic conv_tick,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  // conversion-clock divisor from the clock-select field
  function automatic logic [6:0] div_of(input logic [2:0] sel);
    logic [6:0] d;
    d = DIV_8;
    if (sel[1:0] == 2'b11) begin
      d = DIV_RC;
    end else if (sel == 3'b001) begin
      d = DIV_8;
    end else if (sel == 3'b101) begin
      d = DIV_16;
    end else if (sel == 3'b010) begin
      d = DIV_32;
    end else if (sel == 3'b110) begin
      d = DIV_64;
    end
    return d;
  endfunction

  // channel codes that reach a real node or pin
  function automatic logic chan_ok(input logic [4:0] c);
    logic ok;
    ok = 1'b0;
    if (c[4:3] == 2'b11) begin
      ok = 1'b1;
    end else if (c[4] == 1'b0 && c != 5'b01000 && c != 5'b01001) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] chctl_reg, chctl_next;
  logic [7:0] clkref_reg, clkref_next;
  logic [9:0] result_reg, result_next;
  logic done_reg, done_next;
  logic irq_en_reg, irq_en_next;
  acc_state_t state_reg, state_next;
  logic [6:0] div_cnt_reg, div_cnt_next;
  logic [3:0] per_cnt_reg, per_cnt_next;
  logic aw_hold_reg, aw_hold_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_hold_reg, w_hold_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic sleep_s1_reg, sleep_s2_reg;
  logic wr_fire, tick, run_ok;

  ////////////////////////////////////////////////////////////////////////
  // sleep pin synchroniser, first stage read only by the second

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
    end else if (clk_en) begin
      sleep_s1_reg <= sleep_mode;
      sleep_s2_reg <= sleep_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (aw_addr_reg != ADDR_CHANNEL_CONTROL
          && aw_addr_reg != ADDR_CLOCK_REF_CONTROL
          && aw_addr_reg != ADDR_IRQ_ENABLE
          && aw_addr_reg != ADDR_IRQ_CLEAR
          && aw_addr_reg != ADDR_RESULT_HIGH
          && aw_addr_reg != ADDR_RESULT_LOW
          && aw_addr_reg != ADDR_IRQ_STATUS) begin
        bresp_next = RESP_SLVERR;
      end
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi read channel, one read under way at a time

  assign s_axi_arready = !rvalid_reg;

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0000_0000;
      if (s_axi_araddr == ADDR_CHANNEL_CONTROL) begin
        rdata_next[6:0] = chctl_reg[6:0];
      end else if (s_axi_araddr == ADDR_CLOCK_REF_CONTROL) begin
        rdata_next[7:0] = clkref_reg;
      end else if (s_axi_araddr == ADDR_RESULT_HIGH) begin
        rdata_next[1:0] = result_reg[9:8];
      end else if (s_axi_araddr == ADDR_RESULT_LOW) begin
        rdata_next[7:0] = result_reg[7:0];
      end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
        rdata_next[BIT_DONE] = done_reg;
      end else if (s_axi_araddr == ADDR_IRQ_ENABLE) begin
        rdata_next[BIT_DONE] = irq_en_reg;
      end else if (s_axi_araddr != ADDR_IRQ_CLEAR) begin
        rresp_next = RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion clock divider and sequencer

  // divider idles at zero so every conversion starts on a fresh period
  assign tick = (state_reg != ACC_IDLE)
    && (div_cnt_reg == div_of(clkref_reg[CCS_LSB +: 3]) - 7'd1);
  assign run_ok = chctl_reg[BIT_ENABLE] && !sleep_s2_reg;

  always_comb begin
    chctl_next = chctl_reg;
    clkref_next = clkref_reg;
    result_next = result_reg;
    done_next = done_reg;
    irq_en_next = irq_en_reg;
    state_next = state_reg;
    div_cnt_next = div_cnt_reg;
    per_cnt_next = per_cnt_reg;

    // software writes first, so hardware events below take priority
    if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == ADDR_CHANNEL_CONTROL) begin
        chctl_next = {1'b0, w_data_reg[6:0]};
        // start only takes when the converter is already enabled
        if (!chctl_reg[BIT_ENABLE]) begin
          chctl_next[BIT_START] = 1'b0;
        end
      end else if (aw_addr_reg == ADDR_CLOCK_REF_CONTROL) begin
        clkref_next = {1'b0, w_data_reg[6:4], 3'b000,
          w_data_reg[BIT_REF_SEL]};
      end else if (aw_addr_reg == ADDR_IRQ_ENABLE) begin
        irq_en_next = w_data_reg[BIT_DONE];
      end else if (aw_addr_reg == ADDR_IRQ_CLEAR) begin
        if (w_data_reg[BIT_DONE]) begin
          done_next = 1'b0;
        end
      end
    end

    if (state_reg != ACC_IDLE) begin
      div_cnt_next = tick ? 7'd0 : div_cnt_reg + 7'd1;
    end

    case (state_reg)
      ACC_IDLE: begin
        div_cnt_next = 7'd0;
        per_cnt_next = 4'd0;
        if (chctl_next[BIT_START] && run_ok) begin
          state_next = ACC_CONVERT;
        end else if (!run_ok) begin
          chctl_next[BIT_START] = 1'b0;
        end
      end
      ACC_CONVERT: begin
        if (!chctl_next[BIT_START] || !run_ok) begin
          // abort: result untouched, recovery before reacquire
          chctl_next[BIT_START] = 1'b0;
          state_next = ACC_RECOVER;
          div_cnt_next = 7'd0;
          per_cnt_next = 4'd0;
        end else if (tick) begin
          per_cnt_next = per_cnt_reg + 4'd1;
          if (per_cnt_reg == CONV_PERIODS - 4'd1) begin
            chctl_next[BIT_START] = 1'b0;
            done_next = 1'b1;
            result_next = sample_in.value;
            state_next = ACC_IDLE;
          end
        end
      end
      ACC_RECOVER: begin
        chctl_next[BIT_START] = 1'b0;
        if (tick) begin
          per_cnt_next = per_cnt_reg + 4'd1;
          if (per_cnt_reg == {2'b00, ABORT_PERIODS} - 4'd1) begin
            state_next = ACC_IDLE;
          end
        end
      end
      default: begin
        state_next = ACC_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers; synchronous reset returns everything to idle

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chctl_reg <= RST_CHANNEL_CONTROL;
      clkref_reg <= RST_CLOCK_REF_CONTROL;
      result_reg <= RST_RESULT;
      done_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      state_reg <= ACC_IDLE;
      div_cnt_reg <= 7'd0;
      per_cnt_reg <= 4'd0;
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (clk_en) begin
      chctl_reg <= chctl_next;
      clkref_reg <= clkref_next;
      result_reg <= result_next;
      done_reg <= done_next;
      irq_en_reg <= irq_en_next;
      state_reg <= state_next;
      div_cnt_reg <= div_cnt_next;
      per_cnt_reg <= per_cnt_next;
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // invalid codes route nothing to the sample-and-hold
  assign channel_select = chan_ok(chctl_reg[CHS_LSB +: 5])
    ? chctl_reg[CHS_LSB +: 5] : 5'b01000;
  assign converter_on = run_ok;
  assign reference_select = clkref_reg[BIT_REF_SEL];
  assign sample_hold = (state_reg == ACC_CONVERT);
  // acquiring whenever powered and not converting or recovering
  assign acquire = run_ok && (state_reg == ACC_IDLE);
  assign conv_tick = tick;
  assign irq = done_reg && irq_en_reg;

endmodule

// >>> verif/acc_monitor.sv
`timescale 1ns/1ps
module acc_monitor
  import acc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sleep_mode,
  input wire logic s_axi_bvalid,
  input wire logic converter_on,
  input wire logic reference_select,
  input wire logic sample_hold,
  input wire logic acquire,
  input wire logic conv_tick,
  input wire logic irq
);
  logic [3:0] tick_cnt_reg;
  logic [3:0] tick_cnt_next;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // periods of the running conversion, saturating so it cannot wrap
  always_comb begin
    tick_cnt_next = !sample_hold ? 4'h0 :
      tick_cnt_reg + {3'h0, conv_tick && tick_cnt_reg != 4'hf};
  end
  always_ff @(posedge ref_clk) begin
    tick_cnt_reg <= rst_n ? tick_cnt_next : 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset must clear outputs, so this one is not disabled by it
  AST_RESET_OUT: assert property (disable iff (1'b0)
    !rst_n |=> !sample_hold && !irq && !converter_on && !reference_select)
    else $error("outputs not cleared by reset");
  AST_START_NEEDS_POWER: assert property (
    $rose(sample_hold) |-> $past(converter_on))
    else $error("conversion started while powered down");
  // five samples cover the two-flop synchroniser and the abort edge
  AST_SLEEP_HALTS: assert property (
    sleep_mode [*5] |-> !sample_hold && !converter_on)
    else $error("converter active in sleep");
  AST_ELEVEN_TICKS: assert property (
    sample_hold |-> tick_cnt_reg <= 4'ha)
    else $error("conversion ran past eleven periods");
  AST_TICK_SPACING: assert property (
    conv_tick && sample_hold |=> !conv_tick [*7])
    else $error("conversion clock faster than divide by eight");
  AST_REF_BY_WRITE: assert property (
    $changed(reference_select) |-> $rose(s_axi_bvalid))
    else $error("reference select moved without a write");
  AST_IRQ_RISE: assert property (
    $rose(irq) |-> $past(sample_hold) || $rose(s_axi_bvalid))
    else $error("interrupt rose without completion or write");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a write");

  // main scenarios reached
  CVR_DONE: cover property ($rose(irq));
  CVR_ABORT: cover property ($fell(sample_hold) ##1 !acquire);
  CVR_SLEEP: cover property (sleep_mode && converter_on);
endmodule

bind acc_core acc_monitor mon_u (.*);

// >>> verif/adc_conversion_control_tb_top.sv
`timescale 1ns/1ps
module adc_conversion_control_tb_top
  import acc_pkg::*;
;
  // ready lines tied high: the bench never stalls a response
  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, sleep_mode = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  acc_sample_t sample_in = 11'h000;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsv, bsv;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, converter_on, reference_select, sample_hold;
  logic acquire, conv_tick, irq;
  logic [4:0] channel_select;
  int num_errors = 0, cmp_count = 0, tk, gap;

  acc_core dut_u (.*);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparison and bus helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // each channel dropped at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 99);
    bsv = s_axi_bresp;
    if (n >= 99) num_errors++;
  endtask
  task automatic rd(input logic [7:0] a);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 99);
    rdv = s_axi_rdata;
    rsv = s_axi_rresp;
    if (n >= 99) num_errors++;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    rd(a);
    chk(nm, e, rdv);
  endtask
  // power first, start later; count periods and the first gap
  task automatic conv(input logic [31:0] c);
    int last = 0;
    tk = 0;
    gap = 0;
    wr(ADDR_CHANNEL_CONTROL, c);
    repeat (4) @(posedge ref_clk);
    wr(ADDR_CHANNEL_CONTROL, c | 32'h2);
    for (int n = 0; n < 2000 && (n < 4 || sample_hold === 1'b1); n++) begin
      @(posedge ref_clk);
      if (conv_tick === 1'b1 && sample_hold === 1'b1) begin
        if (tk == 1) gap = n - last;
        last = n;
        tk++;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    rdc("ctl", ADDR_CHANNEL_CONTROL, 32'h0);
    rdc("clkref", ADDR_CLOCK_REF_CONTROL, 32'h0);
    rdc("resh", ADDR_RESULT_HIGH, 32'h0);
    rdc("status", ADDR_IRQ_STATUS, 32'h0);
    chb("refsel", 1'b0, reference_select);
    rd(8'h1c);
    chk("resp", {30'h0, RESP_SLVERR}, {30'h0, rsv});
    wr(8'h1c, 32'h1);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, bsv});
    wr(ADDR_CLOCK_REF_CONTROL, 32'h1);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bsv});
    @(posedge ref_clk);
    chb("refsel", 1'b1, reference_select);
    wr(ADDR_CHANNEL_CONTROL, 32'hfc);
    rdc("ctl", ADDR_CHANNEL_CONTROL, 32'h7c);
  endtask
  task automatic t_chan;
    logic [4:0] e;
    for (int i = 0; i < 32; i++) begin
      e = (i[4:1] == 4'h4 || i[4:3] == 2'h2) ? 5'h08 : i[4:0];
      wr(ADDR_CHANNEL_CONTROL, {25'h0, i[4:0], 2'h0});
      @(posedge ref_clk);
      chk("chan", {27'h0, e}, {27'h0, channel_select});
    end
  endtask
  task automatic t_clk;
    logic [2:0] cs [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int dv [6] = '{8, 16, 32, 64, 16, 16};
    sample_in <= '{1'b1, 10'h2a5};
    wr(ADDR_IRQ_ENABLE, 32'h0);
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_CLOCK_REF_CONTROL, {25'h0, cs[k], 4'h0});
      conv(32'h61);
      chk("gap", dv[k], gap);
      chk("ticks", 32'hb, tk);
    end
    rdc("ctl", ADDR_CHANNEL_CONTROL, 32'h61);
    rdc("resh", ADDR_RESULT_HIGH, 32'h2);
    rdc("resl", ADDR_RESULT_LOW, 32'ha5);
    rdc("status", ADDR_IRQ_STATUS, 32'h1);
    chb("irq", 1'b0, irq);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    @(posedge ref_clk);
    chb("irq", 1'b1, irq);
    wr(ADDR_IRQ_CLEAR, 32'h1);
    @(posedge ref_clk);
    chb("irq", 1'b0, irq);
  endtask
  // abort mid-conversion on the fastest clock
  task automatic t_abort;
    sample_in <= '{1'b1, 10'h15a};
    wr(ADDR_CLOCK_REF_CONTROL, 32'h10);
    wr(ADDR_CHANNEL_CONTROL, 32'h63);
    rdc("ctl", ADDR_CHANNEL_CONTROL, 32'h63);
    repeat (20) @(posedge ref_clk);
    wr(ADDR_CHANNEL_CONTROL, 32'h61);
    tk = 0;
    for (int n = 0; n < 200 && acquire !== 1'b1; n++) begin
      @(posedge ref_clk);
      if (conv_tick === 1'b1 && sample_hold !== 1'b1) tk++;
    end
    chk("recover", 32'h2, tk);
    chb("acquire", 1'b1, acquire);
    rdc("resl", ADDR_RESULT_LOW, 32'ha5);
    rdc("status", ADDR_IRQ_STATUS, 32'h0);
  endtask
  task automatic t_reject;
    wr(ADDR_CHANNEL_CONTROL, 32'h60);
    wr(ADDR_CHANNEL_CONTROL, 32'h62);
    repeat (3) @(posedge ref_clk);
    chb("hold", 1'b0, sample_hold);
    chb("power", 1'b0, converter_on);
    wr(ADDR_CHANNEL_CONTROL, 32'h63);
    repeat (3) @(posedge ref_clk);
    chb("hold", 1'b0, sample_hold);
    chb("power", 1'b1, converter_on);
    rdc("ctl", ADDR_CHANNEL_CONTROL, 32'h61);
  endtask
  // clock enable low freezes a running conversion off its tick cycle
  task automatic t_freeze;
    wr(ADDR_CHANNEL_CONTROL, 32'h63);
    clk_en <= 1'b0;
    repeat (200) @(posedge ref_clk);
    clk_en <= 1'b1;
    chb("frozen", 1'b1, sample_hold);
    for (int n = 0; n < 200 && sample_hold === 1'b1; n++) begin
      @(posedge ref_clk);
    end
    rdc("status", ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h1);
    rdc("status", ADDR_IRQ_STATUS, 32'h0);
  endtask
  task automatic t_sleep;
    wr(ADDR_CHANNEL_CONTROL, 32'h63);
    sleep_mode <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chb("hold", 1'b0, sample_hold);
    chb("power", 1'b0, converter_on);
    sleep_mode <= 1'b0;
    rdc("status", ADDR_IRQ_STATUS, 32'h0);
  endtask
  task automatic t_rst;
    wr(ADDR_CHANNEL_CONTROL, 32'h63);
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chb("hold", 1'b0, sample_hold);
    @(posedge ref_clk);
    rdc("ctl", ADDR_CHANNEL_CONTROL, 32'h0);
    rdc("resl", ADDR_RESULT_LOW, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_chan;
    t_clk;
    t_abort;
    t_reject;
    t_freeze;
    t_sleep;
    t_rst;
    final_report;
  end
  // run needs under ten thousand cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    final_report;
  end
endmodule
